// ===== src/pcr_pkg.sv
// Purpose: constants and types for the port configuration register
// Assumes: management register access by 5-bit address
// Notes: one 16-bit register at address 16
package pcr_pkg;
    localparam logic [4:0] PCR_ADDR = 5'h10;
    localparam int BIT_FORCE_LINK = 14;
    localparam int BIT_TX_DISABLE = 13;
    localparam int BIT_SCR_BYPASS = 12;
    localparam int BIT_JABBER_OFF = 10;
    localparam int BIT_HEARTBEAT = 9;
    localparam int BIT_LOOP_OFF = 8;
    localparam int BIT_CRS_EXT = 7;
    localparam int BIT_SLEEP_EN = 6;
    localparam int BIT_PRE_PASS = 5;
    localparam int BIT_TMR_HI = 4;
    localparam int BIT_TMR_LO = 3;
    localparam int BIT_FAULT_EN = 2;
    localparam int BIT_ALT_NP = 1;
    localparam int BIT_MEDIA = 0;
    // writable bits: all but 15 and 11
    localparam logic [15:0] PCR_WMASK = 16'h77FF;
    localparam logic [15:0] PCR_RESET = 16'h0084;
    localparam logic [1:0] TMR_3S04 = 2'h0;
    localparam logic [1:0] TMR_2S00 = 2'h1;
    localparam logic [1:0] TMR_1S04 = 2'h2;
    // sleep delays in ms
    localparam int SLEEP_MS_3S04 = 3040;
    localparam int SLEEP_MS_2S00 = 2000;
    localparam int SLEEP_MS_1S04 = 1040;
    localparam int CLK_MHZ = 100;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;

    typedef struct packed {
        logic force_link;
        logic tx_disable;
        logic scr_bypass;
        logic jabber_off;
        logic heartbeat_test_enable;
        logic loop_off;
        logic crs_ext;
        logic sleep_en;
        logic pre_pass;
        logic [1:0] sleep_timer;
        logic fault_en;
        logic alt_next_page_enable;
        logic media_sel;
    } pcr_ctrl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pcr_req_t;
endpackage : pcr_pkg

// ===== src/pcr_sleep_timer.sv
// Purpose: inactivity timer that permits sleep
// Assumes: one clock, ms tick derived inside
// Notes: counts in milliseconds
`timescale 1ns/1ps
`default_nettype none
module pcr_sleep_timer #(
    parameter int CYC_MS = pcr_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_enable,
    input wire logic i_activity,
    input wire logic [1:0] i_sel,
    // result
    output logic o_sleep
);
    import pcr_pkg::*;
    logic [31:0] pre_ff;
    logic [11:0] ms_ff;
    logic tick;
    logic [11:0] limit;

    function automatic logic [11:0] ms_of(input logic [1:0] sel);
        case (sel)
            TMR_2S00: ms_of = 12'(SLEEP_MS_2S00);
            TMR_1S04: ms_of = 12'(SLEEP_MS_1S04);
            default: ms_of = 12'(SLEEP_MS_3S04);
        endcase
    endfunction : ms_of

    assign tick = (pre_ff == 32'(CYC_MS - 1));
    assign limit = ms_of(i_sel);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_enable || i_activity) begin
            pre_ff <= '0;
            ms_ff <= '0;
            o_sleep <= 1'b0;
        end else begin
            pre_ff <= tick ? '0 : pre_ff + 32'h1;
            if (tick && ms_ff != limit) begin
                ms_ff <= ms_ff + 12'h1;
            end
            o_sleep <= (ms_ff == limit);
        end
    end
endmodule : pcr_sleep_timer
`default_nettype wire

// ===== src/pcr_port_config.sv
// Purpose: port configuration register and its control effects
// Assumes: management access by address, single-cycle strobes
// Notes: straps sampled while reset is low
`timescale 1ns/1ps
`default_nettype none
module pcr_port_config #(
    parameter int CYC_MS = pcr_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // management access
    input wire pcr_pkg::pcr_req_t i_req,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    // straps
    input wire logic i_sleep_strap,
    input wire logic i_media_select_strap,
    // line status
    input wire logic i_mode_100,
    input wire logic i_mode_10_hdx,
    input wire logic i_line_link,
    input wire logic i_line_activity,
    input wire logic i_crs_raw,
    input wire logic i_sfd_seen,
    input wire logic i_rx_dv_raw,
    input wire logic i_page_rx_indication,
    input wire logic i_page_rx_set,
    input wire logic i_page_rd,
    // control outputs
    output pcr_pkg::pcr_ctrl_t o_ctrl,
    output logic o_link_pass,
    output logic o_tx_enable,
    output logic o_scr_bypass,
    output logic o_jabber_en,
    output logic o_heartbeat_en,
    output logic o_loop_en,
    output logic o_crs,
    output logic o_rx_dv,
    output logic o_fault_tx_en,
    output logic o_fiber,
    output logic o_sleep,
    output logic o_page_rx
);
    import pcr_pkg::*;
    // ------------------------------
    // register
    // ------------------------------
    logic [15:0] reg_ff;
    logic [15:0] nxt_reg;
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic sleep_ok;
    pcr_ctrl_t ctl;

    assign hit = (i_req.addr == PCR_ADDR);
    assign wr_hit = i_req.wr && hit;
    assign rd_hit = i_req.rd && hit;
    // reserved bits never stored, read as zero
    assign nxt_reg = wr_hit ? (i_req.wdata & PCR_WMASK) : reg_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            reg_ff <= PCR_RESET;
            reg_ff[BIT_SLEEP_EN] <= i_sleep_strap;
            reg_ff[BIT_MEDIA] <= i_media_select_strap;
        end else begin
            reg_ff <= nxt_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
        end else begin
            o_rdata <= rd_hit ? reg_ff : 16'h0000;
            o_rvalid <= rd_hit;
        end
    end

    assign ctl = '{
        force_link: reg_ff[BIT_FORCE_LINK],
        tx_disable: reg_ff[BIT_TX_DISABLE],
        scr_bypass: reg_ff[BIT_SCR_BYPASS],
        jabber_off: reg_ff[BIT_JABBER_OFF],
        heartbeat_test_enable: reg_ff[BIT_HEARTBEAT],
        loop_off: reg_ff[BIT_LOOP_OFF],
        crs_ext: reg_ff[BIT_CRS_EXT],
        sleep_en: reg_ff[BIT_SLEEP_EN],
        pre_pass: reg_ff[BIT_PRE_PASS],
        sleep_timer: reg_ff[BIT_TMR_HI:BIT_TMR_LO],
        fault_en: reg_ff[BIT_FAULT_EN],
        alt_next_page_enable: reg_ff[BIT_ALT_NP],
        media_sel: reg_ff[BIT_MEDIA]
    };

    // ------------------------------
    // control decode
    // ------------------------------
    logic nxt_link;
    logic nxt_crs;
    logic nxt_dv;
    logic nxt_page;
    logic page_clr;
    logic in_frame_ff;

    assign nxt_link = ctl.force_link | i_line_link;
    // outside 100M, extension holds CRS while RX_DV is still up
    assign nxt_crs = i_crs_raw | (!i_mode_100 && ctl.crs_ext && i_rx_dv_raw);
    // preamble delivered from CRS in 100M or with pass bit
    assign nxt_dv = (i_mode_100 || ctl.pre_pass) ? i_crs_raw
                  : (i_crs_raw && (i_sfd_seen || in_frame_ff));
    assign page_clr = i_page_rd
        || (ctl.alt_next_page_enable
            && (!i_page_rx_indication || ctl.tx_disable));
    // set wins over clear
    assign nxt_page = i_page_rx_set | (o_page_rx & !page_clr);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            in_frame_ff <= 1'b0;
        end else begin
            in_frame_ff <= i_crs_raw && (in_frame_ff || i_sfd_seen);
        end
    end

    pcr_sleep_timer #(.CYC_MS(CYC_MS)) u_sleep (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_enable(ctl.sleep_en),
        .i_activity(i_line_activity),
        .i_sel(ctl.sleep_timer),
        .o_sleep(sleep_ok)
    );

    // ------------------------------
    // output flops
    // ------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ctrl <= '0;
            o_link_pass <= 1'b0;
            o_tx_enable <= 1'b0;
            o_scr_bypass <= 1'b0;
            o_jabber_en <= 1'b0;
            o_heartbeat_en <= 1'b0;
            o_loop_en <= 1'b0;
            o_crs <= 1'b0;
            o_rx_dv <= 1'b0;
            o_fault_tx_en <= 1'b0;
            o_fiber <= 1'b0;
            o_sleep <= 1'b0;
            o_page_rx <= 1'b0;
        end else begin
            o_ctrl <= ctl;
            o_link_pass <= nxt_link;
            o_tx_enable <= !ctl.tx_disable;
            o_scr_bypass <= i_mode_100 && ctl.scr_bypass;
            o_jabber_en <= i_mode_100 || !ctl.jabber_off;
            o_heartbeat_en <= !i_mode_100 && ctl.heartbeat_test_enable;
            o_loop_en <= i_mode_10_hdx && !ctl.loop_off;
            o_crs <= nxt_crs;
            o_rx_dv <= nxt_dv;
            o_fault_tx_en <= ctl.fault_en;
            o_fiber <= ctl.media_sel;
            o_sleep <= sleep_ok;
            o_page_rx <= nxt_page;
        end
    end

    // ------------------------------
    // checks
    // ------------------------------
    property p_addr;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req.rd && i_req.addr != PCR_ADDR) |=> !o_rvalid;
    endproperty
    a_addr: assert property (p_addr) else $error("read answered off address");
    property p_force;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl.force_link |=> o_link_pass;
    endproperty
    a_force: assert property (p_force) else $error("forced link not passing");
    property p_txdis;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl.tx_disable |=> !o_tx_enable;
    endproperty
    a_txdis: assert property (p_txdis) else $error("transmitter not off");
    property p_hb;
        @(posedge i_clk) disable iff (!i_rst_n)
        !ctl.heartbeat_test_enable |=> !o_heartbeat_en;
    endproperty
    a_hb: assert property (p_hb) else $error("heartbeat while disabled");
    property p_crs;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!i_mode_100 && ctl.crs_ext && i_rx_dv_raw) |=> o_crs;
    endproperty
    a_crs: assert property (p_crs) else $error("crs dropped before rx_dv");
    property p_pre100;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_mode_100 && i_crs_raw) |=> o_rx_dv;
    endproperty
    a_pre100: assert property (p_pre100) else $error("100M preamble not given");
    property p_sfd;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!i_mode_100 && !ctl.pre_pass && !i_sfd_seen && !in_frame_ff) |=> !o_rx_dv;
    endproperty
    a_sfd: assert property (p_sfd) else $error("rx_dv before sfd");
    property p_page;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ctl.alt_next_page_enable && ctl.tx_disable && !i_page_rx_set) |=> !o_page_rx;
    endproperty
    a_page: assert property (p_page) else $error("page flag not cleared");
    property p_rsv;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_rvalid |-> (o_rdata & ~PCR_WMASK) == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
endmodule : pcr_port_config
`default_nettype wire

// ===== verif/pcr_host_model.sv
// Purpose: management host issuing register accesses
// Assumes: one-cycle strobes, answer one cycle after a read
// Notes: released address and data lines show inverted last value
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
    // clock
    input wire logic i_clk,
    // answer
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid,
    // request
    output pcr_pkg::pcr_req_t o_req
);
    import pcr_pkg::*;
    initial o_req = '0;
    // ----------------------------------------
    // write one word
    // ----------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d & PCR_WMASK;
        if (v[4:3] == 2'h3) v[4] = 1'b0;
        @(posedge i_clk);
        o_req <= '{1'b1, 1'b0, a, v};
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b0, ~a, ~v};
    endtask : wr
    // ----------------------------------------
    // read one word
    // ----------------------------------------
    task automatic rd(input logic [4:0] a, output logic ok, output logic [15:0] q);
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b1, a, o_req.wdata};
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b0, ~a, ~o_req.wdata};
        #1;
        ok = i_rvalid;
        q = i_rdata;
    endtask : rd
endmodule : pcr_host_model
`default_nettype wire

// ===== verif/test_phy_port_config_register.sv
// Purpose: self-checking bench of the port configuration register
// Assumes: CYC_MS shortened to 4
// Notes: random writes plus page and sleep corners
`timescale 1ns/1ps
`default_nettype none
module test_phy_port_config_register;
    import pcr_pkg::*;
    logic clk = 0, rst_n = 0, slp_s, med_s, m100 = 0, m10h = 1, act = 0;
    logic pind = 0, pset = 0, prd = 0, ok;
    logic lin = 0, crs_r = 0, sfd = 0, dvr = 0;
    localparam int TB_CYC_MS = 4;
    logic [15:0] rdata, q, v;
    logic rvalid, lnk, txe, scr, jab, hb, lpe, crs, rxdv, flt, fib, slp, prx;
    pcr_req_t req;
    pcr_ctrl_t ctrl;
    int fails = 0, checks = 0;
    logic [31:0] seed = 32'h0000C2D9;
    always #5 clk = ~clk;
    pcr_host_model i_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    pcr_port_config #(.CYC_MS(TB_CYC_MS)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_sleep_strap(slp_s),
        .i_media_select_strap(med_s), .i_mode_100(m100), .i_mode_10_hdx(m10h),
        .i_line_link(lin), .i_line_activity(act), .i_crs_raw(crs_r), .i_sfd_seen(sfd),
        .i_rx_dv_raw(dvr), .i_page_rx_indication(pind), .i_page_rx_set(pset),
        .i_page_rd(prd), .o_ctrl(ctrl), .o_link_pass(lnk), .o_tx_enable(txe),
        .o_scr_bypass(scr), .o_jabber_en(jab), .o_heartbeat_en(hb), .o_loop_en(lpe),
        .o_crs(crs), .o_rx_dv(rxdv), .o_fault_tx_en(flt), .o_fiber(fib),
        .o_sleep(slp), .o_page_rx(prx));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_store(input logic [15:0] d);
        logic [15:0] e;
        e = d & 16'h77FF;
        if (e[4:3] == 2'h3) e[4] = 1'b0;
        return e;
    endfunction : exp_store
    function automatic int exp_ms(input logic [1:0] c);
        if (c == TMR_2S00) return SLEEP_MS_2S00;
        if (c == TMR_1S04) return SLEEP_MS_1S04;
        return SLEEP_MS_3S04;
    endfunction : exp_ms
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic page_pulse(input bit set);
        @(posedge clk);
        if (set) pset <= 1'b1;
        else prd <= 1'b1;
        @(posedge clk);
        pset <= 1'b0;
        prd <= 1'b0;
    endtask : page_pulse
    task automatic frame(input logic m, input logic pre, input logic ext);
        i_host.wr(PCR_ADDR, {8'h00, ext, 1'b0, pre, 5'h04});
        m100 <= m;
        m10h <= ~m;
        crs_r <= 1'b1;
        settle(1);
        chk("dv_pre", {15'h0, m | pre}, {15'h0, rxdv});
        chk("crs_on", 16'h1, {15'h0, crs});
        @(posedge clk);
        sfd <= 1'b1;
        @(posedge clk);
        sfd <= 1'b0;
        dvr <= 1'b1;
        settle(1);
        chk("dv_sfd", 16'h1, {15'h0, rxdv});
        @(posedge clk);
        crs_r <= 1'b0;
        settle(1);
        chk("crs_ext", {15'h0, ~m & ext}, {15'h0, crs});
        chk("dv_off", 16'h0, {15'h0, rxdv});
        @(posedge clk);
        dvr <= 1'b0;
        settle(1);
        chk("crs_off", 16'h0, {15'h0, crs});
    endtask : frame
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        stop_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {slp_s, med_s} = 2'(rnd());
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        i_host.rd(PCR_ADDR, ok, q);
        chk("rvalid", 16'h1, {15'h0, ok});
        chk("reset", 16'h0084 | {9'h0, slp_s, 5'h0, med_s}, q);
        chk("fault_rst", 16'h1, {15'h0, flt});
        i_host.rd(5'h11, ok, q);
        chk("unmapped", 16'h0, {15'h0, ok});
        for (int i = 0; i < 20; i++) begin
            v = 16'(rnd());
            @(posedge clk);
            m100 <= v[15];
            m10h <= ~v[15];
            lin <= v[11];
            i_host.wr(PCR_ADDR, v);
            v = exp_store(v);
            i_host.wr(5'h0F, ~v);
            i_host.rd(PCR_ADDR, ok, q);
            chk("reg", v, q);
            chk("ctrl", {2'h0, v[14:12], v[10:0]}, {2'h0, ctrl});
            chk("link", {15'h0, v[14] | lin}, {15'h0, lnk});
            chk("txen", {15'h0, ~v[13]}, {15'h0, txe});
            chk("fault", {15'h0, v[2]}, {15'h0, flt});
            chk("fiber", {15'h0, v[0]}, {15'h0, fib});
            if (m100) begin
                chk("scr", {15'h0, v[12]}, {15'h0, scr});
            end else begin
                chk("jab", {15'h0, ~v[10]}, {15'h0, jab});
                chk("hb", {15'h0, v[9]}, {15'h0, hb});
                chk("loop", {15'h0, ~v[8]}, {15'h0, lpe});
            end
        end
        @(posedge clk);
        rst_n <= 1'b0;
        slp_s <= ~slp_s;
        med_s <= ~med_s;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        i_host.rd(PCR_ADDR, ok, q);
        chk("reset2", 16'h0084 | {9'h0, slp_s, 5'h0, med_s}, q);
        chk("txen_rst", 16'h1, {15'h0, txe});
        frame(1'b0, 1'b0, 1'b1);
        frame(1'b0, 1'b1, 1'b0);
        frame(1'b1, 1'b0, 1'b1);
        i_host.wr(PCR_ADDR, 16'h0002);
        pind <= 1'b1;
        page_pulse(1);
        settle(2);
        chk("page_set", 16'h1, {15'h0, prx});
        @(posedge clk);
        pind <= 1'b0;
        settle(3);
        chk("page_alt", 16'h0, {15'h0, prx});
        i_host.wr(PCR_ADDR, 16'h0000);
        pind <= 1'b1;
        page_pulse(1);
        pind <= 1'b0;
        settle(3);
        chk("page_hold", 16'h1, {15'h0, prx});
        page_pulse(0);
        settle(2);
        chk("page_rd", 16'h0, {15'h0, prx});
        i_host.wr(PCR_ADDR, 16'h2002);
        pind <= 1'b1;
        page_pulse(1);
        settle(0);
        chk("page_win", 16'h1, {15'h0, prx});
        settle(2);
        chk("page_txdis", 16'h0, {15'h0, prx});
        @(posedge clk);
        pind <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            i_host.wr(PCR_ADDR, {9'h0, 1'b1, 1'b0, 2'(c), 3'h0});
            @(posedge clk);
            act <= 1'b1;
            @(posedge clk);
            act <= 1'b0;
            settle(exp_ms(2'(c)) * TB_CYC_MS - 10);
            chk("sleep_early", 16'h0, {15'h0, slp});
            settle(20);
            chk("sleep_due", 16'h1, {15'h0, slp});
        end
        i_host.wr(PCR_ADDR, 16'h0000);
        settle(4);
        chk("sleep_off", 16'h0, {15'h0, slp});
        stop_test();
    end
endmodule : test_phy_port_config_register
`default_nettype wire
